// >>> common/lgblk_pkg.sv
// Purpose: shared constants for the logic block
// Assumes: one block of eight cells, one fabric clock
// Notes:   configuration bits arrive as plain ports
package lgblk_pkg;
  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int CELLS      = 8;
  localparam int LUT_INPUTS = 4;
  localparam int LUT_DEPTH  = 16;
  localparam int GCLK_COUNT = 8;
  localparam int GCLK_SEL_W = 4;
  // ****************************************************************
  // clock source select encoding
  // ****************************************************************
  localparam logic [3:0] CLK_SRC_FABRIC = 4'h8;
  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic       FF_RESET_VAL = 1'h0;
endpackage : lgblk_pkg

// >>> verilog/lgblk_cell.sv
// Purpose: one logic cell: 4-input lookup and carry; the flip-flop path sits in the block
// Assumes: table contents are configuration, held static
// Notes:   carry is a full-adder style generate/propagate on inputs 1,2
`timescale 1ns/1ps
module lgblk_cell (
  // lookup
  input  wire logic [15:0] i_lut_init,
  input  wire logic [3:0]  i_lut_in,
  // carry
  input  wire logic        i_carry,
  // results
  output logic             o_lut,
  output logic             o_carry
);
  // sixteen-entry one-bit table indexed by the inputs
  assign o_lut   = i_lut_init[i_lut_in];
  // carry generated or propagated by inputs 1 and 2
  assign o_carry = (i_lut_in[1] & i_lut_in[2]) |
                   (i_carry & (i_lut_in[1] | i_lut_in[2]));
endmodule : lgblk_cell

// >>> verilog/lgblk_block.sv
// Purpose: programmable logic block of eight logic cells
// Assumes: clocks are synchronous fabric signals, no synchronisers
// Notes:   configuration bits are static inputs
`timescale 1ns/1ps
module lgblk_block #(
  parameter int N_CELLS = lgblk_pkg::CELLS
) (
  // global clocks and reset
  input  wire logic [lgblk_pkg::GCLK_COUNT-1:0]  i_gclk,
  input  wire logic                              i_clk,
  input  wire logic                              i_resetn,
  // clock source: 0..7 global buffer, fabric code selects i_clk
  input  wire logic [lgblk_pkg::GCLK_SEL_W-1:0]  i_clk_sel,
  // shared controls
  input  wire logic                              i_clk_en,
  input  wire logic                              i_use_clk_en,
  input  wire logic                              i_set_reset,
  input  wire logic                              i_use_sr,
  input  wire logic                              i_sr_async,
  input  wire logic                              i_sr_is_set,
  // per cell configuration
  input  wire logic [16*N_CELLS-1:0]             i_lut_init,
  input  wire logic [N_CELLS-1:0]                i_reg_out,
  // per cell data
  input  wire logic [4*N_CELLS-1:0]              i_lut_in,
  // carry chain
  input  wire logic                              i_fast_carry_input,
  output logic                                   o_fast_carry_output,
  // results
  output logic [N_CELLS-1:0]                     o_cell_out
);
  // ****************************************************************
  // block clock selection
  // ****************************************************************
  logic                 blk_clk;
  logic                 sel_fabric;
  logic [2:0]           gsel;
  assign sel_fabric = (i_clk_sel == lgblk_pkg::CLK_SRC_FABRIC);
  assign gsel       = i_clk_sel[2:0];
  assign blk_clk    = sel_fabric ? i_clk : i_gclk[gsel];

  // ****************************************************************
  // shared control decode
  // ****************************************************************
  logic                 ce;
  logic                 sr_active;
  logic                 async_sr;
  logic                 sync_sr;
  logic                 arst_n;
  logic                 sr_val;
  assign ce        = ~i_use_clk_en | i_clk_en;
  assign sr_active = i_use_sr & i_set_reset;
  assign async_sr  = sr_active & i_sr_async;
  assign sync_sr   = sr_active & ~i_sr_async;
  assign arst_n    = i_resetn & ~async_sr;
  assign sr_val    = i_sr_is_set;

  // ****************************************************************
  // cells and carry chain
  // ****************************************************************
  logic [N_CELLS:0]     carry;
  logic [N_CELLS-1:0]   lut_out;
  logic [N_CELLS-1:0]   ff;
  logic [N_CELLS-1:0]   next_ff;
  assign carry[0]            = i_fast_carry_input;
  assign o_fast_carry_output = carry[N_CELLS];

  genvar g;
  generate
    for (g = 0; g < N_CELLS; g++) begin : g_cell
      lgblk_cell u_cell (
        .i_lut_init (i_lut_init[16*g +: 16]),
        .i_lut_in   (i_lut_in[4*g +: 4]),
        .i_carry    (carry[g]),
        .o_lut      (lut_out[g]),
        .o_carry    (carry[g+1])
      );

      assign next_ff[g] = sync_sr ? sr_val :
                          ce      ? lut_out[g] : ff[g];

      // async path: global reset and local async set/reset both clear
      always_ff @(posedge blk_clk or negedge arst_n) begin
        if (!arst_n) begin
          ff[g] <= lgblk_pkg::FF_RESET_VAL;
        end else begin
          ff[g] <= next_ff[g];
        end
      end

      assign o_cell_out[g] = i_reg_out[g] ? ff[g] : lut_out[g];
    end
  endgenerate

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_ff_reset_clear : assert property (
    @(posedge blk_clk) !i_resetn |-> ff == '0)
    else $error("flip-flops not cleared under global reset");

  chk_ce_hold : assert property (
    @(posedge blk_clk) disable iff (!arst_n)
    (i_use_clk_en && !i_clk_en && !sync_sr) |=> ff == $past(ff))
    else $error("flip-flops moved without clock enable");

  chk_capture_lut : assert property (
    @(posedge blk_clk) disable iff (!arst_n)
    (ce && !sync_sr) |=> ff == $past(lut_out))
    else $error("flip-flop did not capture lookup result");

  chk_sync_sr_apply : assert property (
    @(posedge blk_clk) disable iff (!arst_n)
    sync_sr |=> ff == {N_CELLS{$past(sr_val)}})
    else $error("synchronous set/reset not applied");

  chk_unused_sr : assert property (
    @(posedge blk_clk) disable iff (!arst_n)
    (!i_use_sr && !ce) |=> ff == $past(ff))
    else $error("unused set/reset changed flip-flops");

  chk_lut_table : assert property (
    @(posedge blk_clk)
    lut_out[0] == i_lut_init[i_lut_in[3:0]])
    else $error("lookup does not match table");

  chk_out_select : assert property (
    @(posedge blk_clk)
    o_cell_out == ((i_reg_out & ff) | (~i_reg_out & lut_out)))
    else $error("cell output selection wrong");

  chk_carry_chain : assert property (
    @(posedge blk_clk)
    (carry[0] == i_fast_carry_input) &&
    (o_fast_carry_output == carry[N_CELLS]))
    else $error("carry chain ends wrong");

  chk_async_clear : assert property (
    @(posedge blk_clk)
    async_sr |-> ff == '0)
    else $error("asynchronous clear not applied");

  chk_sr_priority : assert property (
    @(posedge blk_clk) disable iff (!arst_n)
    (sync_sr && !ce) |=> ff == {N_CELLS{$past(sr_val)}})
    else $error("set/reset lost against clock enable");

  chk_ce_unused : assert property (
    @(posedge blk_clk) disable iff (!arst_n)
    (!i_use_clk_en && !sync_sr) |=> ff == $past(lut_out))
    else $error("unused enable blocked a capture");

  // ****************************************************************
  // per cell checks
  // ****************************************************************
  // every cell ripples its own carry and reads its own table
  for (g = 0; g < N_CELLS; g++) begin : g_chk
    chk_carry_ripple : assert property (
      @(posedge blk_clk)
      carry[g+1] == ((i_lut_in[4*g+1] & i_lut_in[4*g+2]) |
                     (carry[g] & (i_lut_in[4*g+1] | i_lut_in[4*g+2]))))
      else $error("carry ripple wrong in a cell");

    chk_lut_cell : assert property (
      @(posedge blk_clk)
      lut_out[g] == i_lut_init[16*g + i_lut_in[4*g +: 4]])
      else $error("cell lookup does not match its table");
  end

  // ****************************************************************
  // coverage
  // ****************************************************************

  cov_sync_sr  : cover property (@(posedge blk_clk) sync_sr);
  cov_ce_off   : cover property (@(posedge blk_clk) i_use_clk_en && !i_clk_en);
  cov_carry_out: cover property (@(posedge blk_clk) o_fast_carry_output);
  cov_reg_mode : cover property (@(posedge blk_clk) &i_reg_out);
  cov_gclk_src : cover property (@(posedge blk_clk) !sel_fabric);
endmodule : lgblk_block

// >>> testbench/lgblk_nbr.sv
// Purpose: neighbouring block seen through its carry output
// Assumes: neighbour carry is plain combinational fabric logic
// Notes:   bench sets the neighbour's carry level
`timescale 1ns/1ps
module lgblk_nbr (
  // neighbour state
  input  wire logic i_gen,
  // carry toward the block under test
  output logic      o_carry
);
  assign o_carry = i_gen;
endmodule : lgblk_nbr

// >>> testbench/tb_top.sv
// Purpose: self-checking bench for the logic block
// Assumes: block clock taken from the fabric clock input, except global buffer 3 in the global clock scenario
// Notes:   global buffer clocks held low, except i_gclk[3] pulsed in the global clock scenario
`timescale 1ns/1ps
module tb_top;
  // ****************************************************************
  // signals
  // ****************************************************************
  localparam logic [127:0] INIT = 128'h0123456789ABCDEFFEDCBA9876543210;
  logic [7:0]   i_gclk = 8'h00;
  logic         i_clk = 1'h0, i_resetn = 1'h0, i_fast_carry_input;
  logic [3:0]   i_clk_sel = lgblk_pkg::CLK_SRC_FABRIC;
  logic         i_clk_en = 1'h0, i_use_clk_en = 1'h0, i_set_reset = 1'h0;
  logic         i_use_sr = 1'h0, i_sr_async = 1'h0, i_sr_is_set = 1'h0;
  logic         nbr_gen = 1'h0, o_fast_carry_output;
  logic [127:0] i_lut_init = INIT;
  logic [7:0]   i_reg_out = 8'h00, o_cell_out;
  logic [31:0]  i_lut_in = 32'h0;
  int           n_mismatch = 0, n_tests = 0, cyc = 0;
  lgblk_block lgblk_block_i (.*);
  lgblk_nbr lgblk_nbr_i (.i_gen(nbr_gen), .o_carry(i_fast_carry_input));
  always #25 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      final_report();
    end
  end
  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [7:0] expv(input int idx);
    for (int g = 0; g < 8; g++) expv[g] = INIT[16*g+idx];
  endfunction : expv
  task automatic check(input logic [7:0] got, exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check
  task automatic edge_in(input int idx);
    @(posedge i_clk);
    i_lut_in <= {8{idx[3:0]}};
  endtask : edge_in
  task automatic final_report();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_lut();
    for (int k = 0; k < 16; k++) begin
      edge_in(k);
      #1 check(o_cell_out, expv(k), "lookup");
    end
  endtask : t_lut
  task automatic t_reg();
    edge_in(5);
    i_reg_out <= 8'hFF;
    i_use_clk_en <= 1'h1;
    repeat (2) @(posedge i_clk);
    #1 check(o_cell_out, expv(15), "enable low holds");
    @(posedge i_clk) i_clk_en <= 1'h1;
    @(posedge i_clk);
    #1 check(o_cell_out, expv(5), "registered capture");
    edge_in(10);
    i_use_clk_en <= 1'h0;
    i_clk_en <= 1'h0;
    @(posedge i_clk);
    #1 check(o_cell_out, expv(10), "enable unused");
  endtask : t_reg
  task automatic t_sr();
    @(posedge i_clk) {i_use_sr, i_set_reset, i_sr_is_set} <= 3'h7;
    @(posedge i_clk) i_sr_is_set <= 1'h0;
    #1 check(o_cell_out, 8'hFF, "sync set");
    @(posedge i_clk) i_use_sr <= 1'h0;
    #1 check(o_cell_out, 8'h00, "sync clear");
    @(posedge i_clk) i_sr_async <= 1'h1;
    #1 check(o_cell_out, expv(10), "unused set/reset");
    @(posedge i_clk) i_use_sr <= 1'h1;
    #1 check(o_cell_out, 8'h00, "async clear");
    @(posedge i_clk) {i_use_sr, i_set_reset, i_sr_async} <= 3'h0;
    @(posedge i_clk) i_resetn <= 1'h0;
    #1 check(o_cell_out, 8'h00, "global reset");
    @(posedge i_clk) i_resetn <= 1'h1;
  endtask : t_sr
  task automatic t_carry();
    @(posedge i_clk) i_lut_in <= {8{4'h2}};
    nbr_gen <= 1'h1;
    #1 check({7'h0, o_fast_carry_output}, 8'h01, "propagate");
    @(posedge i_clk) i_lut_in <= {4'h0, 4'h6, {6{4'h2}}};
    #1 check({7'h0, o_fast_carry_output}, 8'h00, "kill");
    @(posedge i_clk) i_lut_in <= {4'h6, {7{4'h2}}};
    nbr_gen <= 1'h0;
    #1 check({7'h0, o_fast_carry_output}, 8'h01, "generate");
  endtask : t_carry
  task automatic t_gclk();
    edge_in(5);
    @(posedge i_clk) i_clk_sel <= 4'h3;
    i_lut_in <= {8{4'h A}};
    repeat (2) @(posedge i_clk);
    #1 check(o_cell_out, expv(5), "no global edge holds");
    @(posedge i_clk) i_gclk[3] <= 1'h1;
    #1 check(o_cell_out, expv(10), "global buffer clock");
    @(posedge i_clk) i_gclk[3] <= 1'h0;
    i_clk_sel <= lgblk_pkg::CLK_SRC_FABRIC;
  endtask : t_gclk
  initial begin
    repeat (12) @(posedge i_clk);
    i_resetn <= 1'h1;
    t_lut();
    t_reg();
    t_sr();
    t_carry();
    t_gclk();
    final_report();
  end
endmodule : tb_top
